// ### core/ide_cfg.svh
// Constants for the increment, decrement, branch and OR execution slice.
// Assumes inclusion by bare name from the package and the execution modules.
//
// Notes on behaviour
// - Decrement file, destination bit selects, Z only.
// - Clear working register to zero, set Z.
// - Decrement-skip routes result, flags untouched.
// - Decrement-skip zero replaces next instruction with no-op.
// - Increment-skip routes result, flags untouched.
// - Increment-skip zero replaces next instruction with no-op.
// - Branch loads 11-bit literal into low counter.
// - Branch fills counter bits 14:11 from latch 6:3.
// - OR literal into working register, update Z.
// - Increment file, destination bit selects, Z only.
`ifndef IDE_CFG_SVH
`define IDE_CFG_SVH

// =====================================================================
// Widths
// =====================================================================
`define IDE_DATA_W 8
`define IDE_ADDR_W 7
`define IDE_LIT_W 11
`define IDE_PC_W 15
`define IDE_LATCH_W 7

// =====================================================================
// Field positions
// =====================================================================
`define IDE_LATCH_HI 6
`define IDE_LATCH_LO 3
`define IDE_LIT8_HI 7

// =====================================================================
// Values
// =====================================================================
`define IDE_W_RST 8'h00
`define IDE_Z_RST 1'b0
`define IDE_CLEAR_VAL 8'h00
`define IDE_PC_RST 15'h0000
`define IDE_DEST_FILE 1'b1

`endif

// ### core/ide_pkg.sv
// Types shared by the execution slice and its bench.
// Assumes the constants header sits beside it in core/.
`include "ide_cfg.svh"

package ide_pkg;

	// =================================================================
	// Operations
	// =================================================================
	// Operation selector handed over by the decoder.
	typedef enum logic [2:0] {
		op_nop = 3'h0,
		op_decrement_file = 3'h1,
		op_clear_working = 3'h2,
		op_decrement_skip_zero = 3'h3,
		op_increment_skip_zero = 3'h4,
		op_branch_absolute = 3'h5,
		op_or_literal_working = 3'h6,
		op_increment_file = 3'h7
	} ide_op_e;

	// =================================================================
	// Carriers
	// =================================================================
	// One decoded instruction.
	typedef struct packed {
		ide_op_e op;
		logic [`IDE_ADDR_W-1:0] addr;
		logic dest;
		logic [`IDE_LIT_W-1:0] lit;
	} ide_req_s;

	// A write toward the file register.
	typedef struct packed {
		logic we;
		logic [`IDE_ADDR_W-1:0] addr;
		logic [`IDE_DATA_W-1:0] data;
	} ide_fwr_s;

	// A program counter load.
	typedef struct packed {
		logic load;
		logic [`IDE_PC_W-1:0] target;
	} ide_pc_s;

endpackage : ide_pkg

// ### core/ide_step.sv
// Increment or decrement unit with zero detection.
// Assumes the operand comes from logic on the same clock.
`timescale 1ns/1ps
`include "ide_cfg.svh"

module ide_step #(
	parameter int WIDTH = `IDE_DATA_W
) (
	// Operand and direction.
	input wire logic [WIDTH-1:0] operand,
	input wire logic dec,
	// Result.
	output logic [WIDTH-1:0] result,
	output logic zero
);

	// The sum is kept at operand width so it wraps on overflow.
	always_comb begin
		if (dec) begin
			result = operand - WIDTH'(1);
		end else begin
			result = operand + WIDTH'(1);
		end
		zero = (result == '0);
	end

endmodule // ide_step

// ### core/ide_exec.sv
// Execution slice for increment, decrement, skip, clear, branch and OR literal.
// Assumes the decoder presents one instruction per cycle with the addressed
// file register already read onto file_rdata in the same cycle.
`timescale 1ns/1ps
`include "ide_cfg.svh"

module ide_exec (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Decoded instruction and its operands.
	input wire logic req_valid,
	input wire ide_pkg::ide_req_s req,
	input wire logic [`IDE_DATA_W-1:0] file_rdata,
	input wire logic [`IDE_LATCH_W-1:0] pc_upper_latch,
	// Results toward the core.
	output ide_pkg::ide_fwr_s fwr_q,
	output ide_pkg::ide_pc_s pc_q,
	output logic [`IDE_DATA_W-1:0] w_q,
	output logic z_q,
	output logic skip_pend_q,
	output logic squash_q
);

	// =================================================================
	// Issue control
	// =================================================================
	// An instruction executes only when no skip is pending.
	logic go;
	// A pending skip turns the arriving instruction into a no-op.
	logic kill;
	// Destination bit selects the file register.
	logic to_file;
	// Decrement direction for the step unit.
	logic step_dec;
	// Step unit outputs.
	logic [`IDE_DATA_W-1:0] step_res;
	logic step_zero;
	// OR literal result.
	logic [`IDE_DATA_W-1:0] or_res;

	assign go = req_valid && !skip_pend_q;
	assign kill = req_valid && skip_pend_q;
	assign to_file = (req.dest == `IDE_DEST_FILE);
	assign step_dec = (req.op == ide_pkg::op_decrement_file) ||
		(req.op == ide_pkg::op_decrement_skip_zero);
	assign or_res = w_q | req.lit[`IDE_LIT8_HI:0];

	// =================================================================
	// Arithmetic
	// =================================================================
	// Shared unit; one instruction uses it per cycle.
	ide_step #(
		.WIDTH(`IDE_DATA_W)
	) u_step (
		.operand(file_rdata),
		.dec(step_dec),
		.result(step_res),
		.zero(step_zero)
	);

	// =================================================================
	// Working register
	// =================================================================
	// Updated by clear, OR literal and by steps aimed at W.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			w_q <= `IDE_W_RST;
		end else if (go) begin
			unique case (req.op)
				ide_pkg::op_clear_working: begin
					w_q <= `IDE_CLEAR_VAL;
				end
				ide_pkg::op_or_literal_working: begin
					w_q <= or_res;
				end
				ide_pkg::op_decrement_file, ide_pkg::op_increment_file,
				ide_pkg::op_decrement_skip_zero, ide_pkg::op_increment_skip_zero: begin
					if (!to_file) begin
						w_q <= step_res;
					end
				end
				// Branch and no-op leave W alone.
				ide_pkg::op_branch_absolute, ide_pkg::op_nop: begin
					w_q <= w_q;
				end
			endcase
		end
	end

	// =================================================================
	// Zero flag
	// =================================================================
	// Skip instructions and the branch never touch the flag.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			z_q <= `IDE_Z_RST;
		end else if (go) begin
			unique case (req.op)
				ide_pkg::op_clear_working: begin
					z_q <= 1'b1;
				end
				ide_pkg::op_or_literal_working: begin
					z_q <= (or_res == '0);
				end
				ide_pkg::op_decrement_file, ide_pkg::op_increment_file: begin
					z_q <= step_zero;
				end
				// Skip forms keep flags; so does the branch.
				ide_pkg::op_decrement_skip_zero, ide_pkg::op_increment_skip_zero,
				ide_pkg::op_branch_absolute, ide_pkg::op_nop: begin
					z_q <= z_q;
				end
			endcase
		end
	end

	// =================================================================
	// File register write
	// =================================================================
	// A one-cycle write strobe for steps with the destination bit set.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fwr_q <= '0;
		end else begin
			// Step results routed to the file register.
			fwr_q.we <= go && to_file && ((req.op == ide_pkg::op_decrement_file) ||
				(req.op == ide_pkg::op_increment_file) ||
				(req.op == ide_pkg::op_decrement_skip_zero) ||
				(req.op == ide_pkg::op_increment_skip_zero));
			fwr_q.addr <= req.addr;
			fwr_q.data <= step_res;
		end
	end

	// =================================================================
	// Program counter load
	// =================================================================
	// A one-cycle load request with the full branch target.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pc_q.load <= 1'b0;
			pc_q.target <= `IDE_PC_RST;
		end else begin
			pc_q.load <= go && (req.op == ide_pkg::op_branch_absolute);
			if (go && (req.op == ide_pkg::op_branch_absolute)) begin
				pc_q.target[`IDE_LIT_W-1:0] <= req.lit;
				pc_q.target[`IDE_PC_W-1:`IDE_LIT_W] <=
					pc_upper_latch[`IDE_LATCH_HI:`IDE_LATCH_LO];
			end
		end
	end

	// =================================================================
	// Skip handling
	// =================================================================
	// A zero skip result arms the pending flag; the next instruction that
	// arrives is dropped, which costs the skip its second cycle.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			skip_pend_q <= 1'b0;
			squash_q <= 1'b0;
		end else begin
			squash_q <= kill;
			if (kill) begin
				skip_pend_q <= 1'b0;
			end else if (go) begin
				skip_pend_q <= step_zero &&
					((req.op == ide_pkg::op_decrement_skip_zero) ||
					(req.op == ide_pkg::op_increment_skip_zero));
			end
		end
	end

	// =================================================================
	// Checks
	// =================================================================
	// Reference results computed apart from the step unit.
	logic [`IDE_DATA_W-1:0] dec_ref;
	logic [`IDE_DATA_W-1:0] inc_ref;
	assign dec_ref = file_rdata - 8'h01;
	assign inc_ref = file_rdata + 8'h01;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	dec_to_work_a: assert property (
		go && req.op == ide_pkg::op_decrement_file && !req.dest
		|=> w_q == $past(dec_ref) && z_q == ($past(dec_ref) == 8'h00) && !fwr_q.we)
		else $error("decrement to W gave a wrong result or flag");

	clear_work_a: assert property (
		go && req.op == ide_pkg::op_clear_working
		|=> w_q == 8'h00 && z_q)
		else $error("clear did not zero W and set Z");

	dskip_flags_a: assert property (
		go && req.op == ide_pkg::op_decrement_skip_zero && req.dest
		|=> $stable(z_q) && $stable(w_q) && fwr_q.we && fwr_q.data == $past(dec_ref))
		else $error("decrement skip touched flags or wrote wrong data");

	dskip_nop_a: assert property (
		go && req.op == ide_pkg::op_decrement_skip_zero
		&& dec_ref == 8'h00 ##1 req_valid
		|=> squash_q && !skip_pend_q && !pc_q.load && !fwr_q.we && $stable(w_q))
		else $error("zero decrement skip did not drop the next instruction");

	iskip_flags_a: assert property (
		go && req.op == ide_pkg::op_increment_skip_zero && !req.dest
		|=> $stable(z_q) && w_q == $past(inc_ref))
		else $error("increment skip touched flags or gave a wrong W");

	iskip_nop_a: assert property (
		go && req.op == ide_pkg::op_increment_skip_zero
		|=> skip_pend_q == ($past(inc_ref) == 8'h00))
		else $error("increment skip armed the no-op wrongly");

	branch_low_a: assert property (
		go && req.op == ide_pkg::op_branch_absolute
		|=> pc_q.load && pc_q.target[10:0] == $past(req.lit) && $stable(z_q))
		else $error("branch low target bits wrong");

	branch_high_a: assert property (
		go && req.op == ide_pkg::op_branch_absolute
		|=> pc_q.target[14:11] == $past(pc_upper_latch[6:3]))
		else $error("branch high target bits wrong");

	or_literal_a: assert property (
		go && req.op == ide_pkg::op_or_literal_working
		|=> w_q == ($past(w_q) | $past(req.lit[7:0])) && z_q == (w_q == 8'h00))
		else $error("OR literal gave a wrong W or flag");

	inc_to_file_a: assert property (
		go && req.op == ide_pkg::op_increment_file && req.dest
		|=> fwr_q.we && fwr_q.data == $past(inc_ref) && $stable(w_q))
		else $error("increment to file wrote wrong data");

	inc_wrap_a: assert property (
		go && req.op == ide_pkg::op_increment_file
		&& file_rdata == 8'hFF |=> z_q)
		else $error("increment of FF did not wrap to zero");

endmodule // ide_exec

// ### sim/tb_top.sv
// Self-checking bench for the increment, decrement, skip, clear, branch and OR slice.
// Assumes the execution slice and its package are compiled first from core/.
`timescale 1ns/1ps
`include "ide_cfg.svh"

module tb_top;

	// =================================================================
	// Stimulus and observation
	// =================================================================
	// Clock, reset and instruction inputs driven by the bench.
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic req_valid = 1'b0;
	ide_pkg::ide_req_s req = '0;
	logic [7:0] file_rdata = 8'h00;
	logic [6:0] pc_upper_latch = 7'h00;
	// Results seen from the slice.
	ide_pkg::ide_fwr_s fwr_q;
	ide_pkg::ide_pc_s pc_q;
	logic [7:0] w_q;
	logic z_q;
	logic skip_pend_q;
	logic squash_q;
	// Counters of comparisons and of mismatches.
	int comparisons = 0;
	int miscompares = 0;

	// The clock toggles every half period of 2.5 ns.
	always #2.5 clk_sys = ~clk_sys;

	// The slice under test.
	ide_exec dut (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.req_valid(req_valid),
		.req(req),
		.file_rdata(file_rdata),
		.pc_upper_latch(pc_upper_latch),
		.fwr_q(fwr_q),
		.pc_q(pc_q),
		.w_q(w_q),
		.z_q(z_q),
		.skip_pend_q(skip_pend_q),
		.squash_q(squash_q)
	);

	// =================================================================
	// Shared tasks
	// =================================================================
	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Presents one instruction; called just after a rising edge.
	task automatic drv(input ide_pkg::ide_op_e op, input logic [6:0] a, input logic d,
		input logic [10:0] k, input logic [7:0] rd);
		req_valid <= 1'b1;
		req <= '{op: op, addr: a, dest: d, lit: k};
		file_rdata <= rd;
	endtask

	// Runs one instruction and returns once its results have landed.
	task automatic run(input ide_pkg::ide_op_e op, input logic [6:0] a, input logic d,
		input logic [10:0] k, input logic [7:0] rd);
		@(posedge clk_sys);
		drv(op, a, d, k, rd);
		@(posedge clk_sys);
		req_valid <= 1'b0;
		#1;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// =================================================================
	// Scenarios
	// =================================================================
	// Decrement with both destinations, including the wrap below zero.
	task automatic t_decrement();
		run(ide_pkg::op_decrement_file, 7'h05, 1'b0, 11'h000, 8'h01);
		chk("dec w", 16'h0000, w_q);
		chk("dec z set", 16'h0001, z_q);
		chk("dec no write", 16'h0000, fwr_q.we);
		run(ide_pkg::op_decrement_file, 7'h7F, 1'b1, 11'h000, 8'h00);
		chk("dec we", 16'h0001, fwr_q.we);
		chk("dec addr", 16'h007F, fwr_q.addr);
		chk("dec wrap", 16'h00FF, fwr_q.data);
		chk("dec w kept", 16'h0000, w_q);
		chk("dec z clr", 16'h0000, z_q);
		$display("test decrement done");
	endtask

	// Increment with both destinations, including the wrap above 255.
	task automatic t_increment();
		run(ide_pkg::op_increment_file, 7'h00, 1'b1, 11'h000, 8'hFF);
		chk("inc wrap", 16'h0000, fwr_q.data);
		chk("inc we", 16'h0001, fwr_q.we);
		chk("inc z set", 16'h0001, z_q);
		run(ide_pkg::op_increment_file, 7'h22, 1'b0, 11'h000, 8'h7F);
		chk("inc w", 16'h0080, w_q);
		chk("inc z clr", 16'h0000, z_q);
		chk("inc no write", 16'h0000, fwr_q.we);
		$display("test increment done");
	endtask

	// OR literal uses only the low eight literal bits and sets Z by the result.
	// A no-op leaves W, Z and the file register alone.
	task automatic t_or_clear();
		run(ide_pkg::op_or_literal_working, 7'h00, 1'b0, 11'h75A, 8'h00);
		chk("or w", 16'h00DA, w_q);
		chk("or z", 16'h0000, z_q);
		run(ide_pkg::op_or_literal_working, 7'h00, 1'b0, 11'h725, 8'h00);
		chk("or acc", 16'h00FF, w_q);
		run(ide_pkg::op_clear_working, 7'h00, 1'b0, 11'h000, 8'h00);
		chk("clr w", 16'h0000, w_q);
		chk("clr z", 16'h0001, z_q);
		run(ide_pkg::op_increment_file, 7'h01, 1'b1, 11'h000, 8'h00);
		chk("pre or z", 16'h0000, z_q);
		run(ide_pkg::op_or_literal_working, 7'h00, 1'b0, 11'h700, 8'h00);
		chk("or zero z", 16'h0001, z_q);
		run(ide_pkg::op_nop, 7'h01, 1'b1, 11'h0FF, 8'hFF);
		chk("nop we", 16'h0000, fwr_q.we);
		chk("nop w", 16'h0000, w_q);
		chk("nop z", 16'h0001, z_q);
		$display("test or_clear done");
	endtask

	// Decrement-skip on zero drops the next instruction even after an idle cycle.
	task automatic t_dec_skip();
		run(ide_pkg::op_decrement_skip_zero, 7'h11, 1'b1, 11'h000, 8'h01);
		chk("dsz data", 16'h0000, fwr_q.data);
		chk("dsz we", 16'h0001, fwr_q.we);
		chk("dsz pend", 16'h0001, skip_pend_q);
		chk("dsz z kept", 16'h0001, z_q);
		@(posedge clk_sys);
		#1;
		chk("idle keeps pend", 16'h0001, skip_pend_q);
		run(ide_pkg::op_increment_file, 7'h12, 1'b0, 11'h000, 8'h41);
		chk("dropped w", 16'h0000, w_q);
		chk("squash", 16'h0001, squash_q);
		chk("pend clr", 16'h0000, skip_pend_q);
		chk("dropped we", 16'h0000, fwr_q.we);
		run(ide_pkg::op_decrement_skip_zero, 7'h11, 1'b0, 11'h000, 8'h05);
		chk("dsz w", 16'h0004, w_q);
		chk("dsz no pend", 16'h0000, skip_pend_q);
		chk("dsz z nz", 16'h0001, z_q);
		@(posedge clk_sys);
		drv(ide_pkg::op_decrement_skip_zero, 7'h11, 1'b0, 11'h000, 8'h01);
		@(posedge clk_sys);
		drv(ide_pkg::op_or_literal_working, 7'h00, 1'b0, 11'h0FF, 8'h00);
		@(posedge clk_sys);
		req_valid <= 1'b0;
		#1;
		chk("dsz back squash", 16'h0001, squash_q);
		chk("dsz back w", 16'h0000, w_q);
		chk("dsz back z", 16'h0001, z_q);
		$display("test dec_skip done");
	endtask

	// Increment-skip on zero drops a branch that follows back to back.
	task automatic t_inc_skip();
		run(ide_pkg::op_or_literal_working, 7'h00, 1'b0, 11'h010, 8'h00);
		@(posedge clk_sys);
		drv(ide_pkg::op_increment_skip_zero, 7'h33, 1'b0, 11'h000, 8'hFF);
		@(posedge clk_sys);
		drv(ide_pkg::op_branch_absolute, 7'h00, 1'b0, 11'h123, 8'h00);
		#1;
		chk("isz w", 16'h0000, w_q);
		chk("isz z kept", 16'h0000, z_q);
		chk("isz pend", 16'h0001, skip_pend_q);
		@(posedge clk_sys);
		req_valid <= 1'b0;
		#1;
		chk("isz squash", 16'h0001, squash_q);
		chk("isz no load", 16'h0000, pc_q.load);
		run(ide_pkg::op_increment_skip_zero, 7'h33, 1'b1, 11'h000, 8'h00);
		chk("isz data", 16'h0001, fwr_q.data);
		chk("isz no pend", 16'h0000, skip_pend_q);
		$display("test inc_skip done");
	endtask

	// Branch target joins latch bits 6:3 above the eleven-bit literal.
	task automatic t_branch();
		pc_upper_latch <= 7'h5A;
		run(ide_pkg::op_branch_absolute, 7'h00, 1'b0, 11'h7FF, 8'h00);
		chk("br load", 16'h0001, pc_q.load);
		chk("br target", 16'h5FFF, pc_q.target);
		chk("br z kept", 16'h0000, z_q);
		pc_upper_latch <= 7'h47;
		run(ide_pkg::op_branch_absolute, 7'h00, 1'b0, 11'h001, 8'h00);
		chk("br target2", 16'h4001, pc_q.target);
		@(posedge clk_sys);
		#1;
		chk("br pulse", 16'h0000, pc_q.load);
		chk("br held", 16'h4001, pc_q.target);
		$display("test branch done");
	endtask

	// =================================================================
	// Main sequence
	// =================================================================
	// Holds reset for three cycles, checks reset values, then runs each scenario.
	initial begin
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		chk("rst w", 16'h0000, w_q);
		chk("rst z", 16'h0000, z_q);
		chk("rst target", 16'h0000, pc_q.target);
		chk("rst pend", 16'h0000, skip_pend_q);
		$display("test reset done");
		t_decrement();
		t_increment();
		t_or_clear();
		t_dec_skip();
		t_inc_skip();
		t_branch();
		print_verdict();
	end

endmodule // tb_top
